/* File: src/asram_host.sv */
// Purpose: host side controller driving an asynchronous 32K x 8 static memory
// Assumes: one clock, synchronous active high reset, inputs synchronous
// Notes: chip-select-controlled writes; one request at a time
`timescale 1ns/1ns
`include "asram_params.svh"
module asram_host (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire asram_pkg::asram_addr_t i_req_addr,
  input wire asram_pkg::asram_data_t i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output asram_pkg::asram_data_t o_rsp_rdata,
  output asram_pkg::asram_pins_t o_pins,
  input wire asram_pkg::asram_data_t i_data_io_bus
);
  import asram_pkg::*;

  localparam logic [3:0] WR_HOLD = 4'(`ASRAM_SEL_END_CYCLES);
  localparam logic [3:0] RD_HOLD = 4'(`ASRAM_READ_CYCLES);
  localparam logic [3:0] GAP_HOLD = 4'(`ASRAM_RELEASE_CYCLES);

  // --------------------------------------------------------------------
  // state and datapath registers
  // --------------------------------------------------------------------
  asram_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  asram_pins_t pins_q, pins_d;
  asram_data_t rdata_q, rdata_d;
  logic rsp_q, rsp_d;

  // decode of the controller position
  wire idle_w = (state_q == ST_IDLE);
  wire cnt_done_w = (cnt_q == 4'h0);
  wire take_w = idle_w && i_req_valid && cnt_done_w;

  assign o_req_ready = idle_w && cnt_done_w;
  assign o_rsp_valid = rsp_q;
  assign o_rsp_rdata = rdata_q;
  assign o_pins = pins_q;

  // next state: write enable falls before select and rises after it
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done_w ? 4'h0 : cnt_q - 4'h1;
    pins_d = pins_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take_w) begin
          pins_d.word_addr_bus = i_req_addr;
          if (i_req_write) begin
            pins_d.write_n = 1'b0;
            pins_d.data_out = i_req_wdata;
            pins_d.data_oe = 1'b1;
            state_d = ST_WR_STROBE;
          end else begin
            pins_d.write_n = 1'b1;
            pins_d.select_n = 1'b0;
            pins_d.out_en_n = 1'b0;
            cnt_d = RD_HOLD;
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_WR_STROBE: begin
        pins_d.select_n = 1'b0;
        cnt_d = WR_HOLD;
        state_d = ST_WR_END;
      end
      ST_WR_END: begin
        if (cnt_done_w) begin
          pins_d.select_n = 1'b1;
          state_d = ST_RD_END;
        end
      end
      ST_RD_WAIT: begin
        if (cnt_done_w) begin
          rdata_d = i_data_io_bus;
          rsp_d = 1'b1;
          pins_d.select_n = 1'b1;
          pins_d.out_en_n = 1'b1;
          cnt_d = GAP_HOLD;
          state_d = ST_IDLE;
        end
      end
      ST_RD_END: begin
        pins_d.write_n = 1'b1;
        pins_d.data_oe = 1'b0;
        cnt_d = GAP_HOLD;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // registers advance only with the clock enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      pins_q <= '{select_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                  word_addr_bus: '0, data_out: '0, data_oe: 1'b0};
      rdata_q <= '0;
      rsp_q <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pins_q <= pins_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
    end
  end

  // --------------------------------------------------------------------
  // checks on the pin sequence
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !i_clk_en);

  // write enable leads, select follows one cycle later
  sequence s_write_open;
    !o_pins.write_n && o_pins.select_n ##1 !o_pins.write_n && !o_pins.select_n;
  endsequence

  // select has just risen to close a write
  sequence s_write_end;
    $rose(o_pins.select_n) && !$past(o_pins.write_n);
  endsequence

  // write enable still low, then high one cycle later
  sequence s_write_release;
    !o_pins.write_n ##1 o_pins.write_n;
  endsequence

  // select and output enable fall together for a read
  sequence s_read_open;
    $fell(o_pins.out_en_n) && !o_pins.select_n && o_pins.write_n;
  endsequence

  // host data drives the pins for the whole strobe overlap
  a_write_under_strobe: assert property (
    !o_pins.select_n && !o_pins.write_n |-> o_pins.data_oe)
    else $error("write strobe without host data drive");

  // select only falls once write enable is already low
  a_select_after_write: assert property (
    $fell(o_pins.select_n) && !o_pins.write_n |-> !$past(o_pins.write_n))
    else $error("select fell before write enable");

  // write enable outlasts select by one cycle
  a_select_rise_first: assert property (
    s_write_end |-> s_write_release)
    else $error("write enable did not outlast select");

  // address holds for two cycles once the strobes overlap
  a_write_cycle_len: assert property (
    s_write_open |-> ##1 $stable(o_pins.word_addr_bus)[*2])
    else $error("address changed inside write cycle");

  // select stays low for at least two cycles in a write
  a_select_width: assert property (
    $fell(o_pins.select_n) && !o_pins.write_n |-> !o_pins.select_n[*2])
    else $error("select low too short in write");

  // address may not move once select is low
  a_read_addr_first: assert property (
    !o_pins.select_n && !$past(o_pins.select_n) |-> $stable(o_pins.word_addr_bus))
    else $error("address moved while selected");

  // the address on the pins is the one that was taken
  a_addr_from_req: assert property (
    take_w |=> o_pins.word_addr_bus == $past(i_req_addr))
    else $error("pin address differs from request");

  // write data holds while the strobes overlap
  a_write_data_hold: assert property (
    !o_pins.select_n && !o_pins.write_n && !$past(o_pins.select_n)
    |-> $stable(o_pins.data_out))
    else $error("write data moved inside strobe");

  // host stops driving data once the write has closed
  a_write_close: assert property (
    s_write_end ##1 o_pins.write_n |-> !o_pins.data_oe && o_pins.select_n)
    else $error("host still drives after write");

  // reads keep write enable high and host data off
  a_read_write_high: assert property (
    !o_pins.out_en_n |-> o_pins.write_n && !o_pins.data_oe)
    else $error("write enable low during read");

  // read answer two cycles after output enable falls
  a_read_answer: assert property (
    s_read_open |-> ##2 o_rsp_valid)
    else $error("read answer not on time");

  // answer stands for one enabled cycle only
  a_rsp_single: assert property (
    o_rsp_valid |=> !o_rsp_valid)
    else $error("read answer longer than one cycle");

  // no new request while the memory lets go of the bus
  a_release_gap: assert property (
    $rose(o_pins.select_n) |-> !o_req_ready)
    else $error("new request taken without release gap");
endmodule

/* File: src/asram_params.svh */
// Purpose: timing constants and widths for the static memory host controller
// Assumes: 20 MHz system clock, fastest speed grade of the memory
// Notes: times are in picoseconds so fractional nanoseconds stay exact
`ifndef ASRAM_PARAMS_SVH
`define ASRAM_PARAMS_SVH

`define ASRAM_CLK_PERIOD_PS 50000
`define ASRAM_ADDR_W 15
`define ASRAM_DATA_W 8
// write cycle time, least
`define ASRAM_WRITE_CYCLE_PS 6000
// address valid to end of write, least
`define ASRAM_ADDR_TO_END_PS 6000
// select low to end of write, least
`define ASRAM_SELECT_TO_WRITE_END_PS 5000
// write low to output off, longest
`define ASRAM_WRITE_LOW_TO_OUTPUT_OFF_PS 3500
// write high to output on, least
`define ASRAM_WRITE_HIGH_TO_OUTPUT_ON_PS 3000
// output enable access, longest
`define ASRAM_OE_ACCESS_PS 4000
// select high to output off, longest
`define ASRAM_SELECT_OFF_PS 3000

// least times round up, at least one cycle
`define ASRAM_CYC_UP(t) ((((t) + `ASRAM_CLK_PERIOD_PS - 1) / `ASRAM_CLK_PERIOD_PS) < 1 ? 1 : \
  (((t) + `ASRAM_CLK_PERIOD_PS - 1) / `ASRAM_CLK_PERIOD_PS))
`define ASRAM_WRITE_CYCLES `ASRAM_CYC_UP(`ASRAM_WRITE_CYCLE_PS)
`define ASRAM_ADDR_END_CYCLES `ASRAM_CYC_UP(`ASRAM_ADDR_TO_END_PS)
`define ASRAM_SEL_END_CYCLES `ASRAM_CYC_UP(`ASRAM_SELECT_TO_WRITE_END_PS)
`define ASRAM_TURN_CYCLES `ASRAM_CYC_UP(`ASRAM_WRITE_LOW_TO_OUTPUT_OFF_PS)
`define ASRAM_READ_CYCLES `ASRAM_CYC_UP(`ASRAM_OE_ACCESS_PS)
`define ASRAM_RELEASE_CYCLES `ASRAM_CYC_UP(`ASRAM_SELECT_OFF_PS)

`endif

/* File: src/asram_pkg.sv */
// Purpose: types shared by the static memory host controller
// Assumes: widths from asram_params.svh
// Notes: pin group travels as one packed struct
`include "asram_params.svh"
package asram_pkg;
  typedef logic [`ASRAM_ADDR_W-1:0] asram_addr_t;
  typedef logic [`ASRAM_DATA_W-1:0] asram_data_t;

  // pins driven toward the memory, strobes active low
  typedef struct packed {
    logic select_n;
    logic out_en_n;
    logic write_n;
    asram_addr_t word_addr_bus;
    asram_data_t data_out;
    logic data_oe;
  } asram_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_STROBE = 3'b001,
    ST_WR_END = 3'b010,
    ST_RD_WAIT = 3'b011,
    ST_RD_END = 3'b100
  } asram_state_t;
endpackage

/* File: test/asram_host_tb_top.sv */
// Purpose: self-checking bench for the memory host
// Assumes: 50 ns clock, inputs change at the falling edge
// Notes: reads only touch words already written
`timescale 1ns/1ns
module asram_host_tb_top;
  import asram_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_req_valid = 1'b0;
  logic i_req_write = 1'b0;
  logic i_slow = 1'b0;
  asram_addr_t i_req_addr = '0;
  asram_data_t i_req_wdata = '0;
  logic o_req_ready;
  logic o_rsp_valid;
  asram_data_t o_rsp_rdata;
  asram_pins_t o_pins;
  logic [7:0] bus_level;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] seed_q = 32'h34;
  logic [7:0] ref_q [asram_addr_t];
  asram_host u_asram_host (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata), .o_pins(o_pins), .i_data_io_bus(bus_level));
  asram_mem_model u_mem (.i_pins(o_pins), .i_slow(i_slow), .o_level(bus_level));
  initial forever #25 i_clock = ~i_clock;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed_q ^= seed_q << 13;
    seed_q ^= seed_q >> 17;
    seed_q ^= seed_q << 5;
    return seed_q;
  endfunction
  function automatic asram_data_t exp_read(asram_addr_t a);
    return ref_q.exists(a) ? ref_q[a] : 8'h00;
  endfunction
  task automatic check_byte(string what, asram_data_t exp, asram_data_t got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_bit(string what, logic exp, logic got);
    check_byte(what, {7'h00, exp}, {7'h00, got});
  endtask
  // one request, held until taken
  task automatic do_req(logic wr, asram_addr_t a, asram_data_t d);
    int n;
    n = 0;
    @(negedge i_clock);
    i_req_valid = 1'b1;
    i_req_write = wr;
    i_req_addr = a;
    i_req_wdata = d;
    do begin
      @(posedge i_clock);
      n++;
    end while (!(i_clk_en && o_req_ready) && n < 50);
    if (!(i_clk_en && o_req_ready)) bad_count++;
    @(negedge i_clock);
    i_req_valid = 1'b0;
    check_bit("ready after take", 1'b0, o_req_ready);
    if (wr) ref_q[a] = d;
    n = 0;
    while (!wr && o_rsp_valid !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    if (!wr) check_bit("read answer", 1'b1, o_rsp_valid);
    if (!wr) check_byte("read data", exp_read(a), o_rsp_rdata);
  endtask
  task automatic complete_run();
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // random enable and memory speed
  always @(negedge i_clock) if (!i_rst) {i_clk_en, i_slow} <= {xs() % 4 != 0, seed_q[9]};
  // pin watch
  always @(negedge i_clock) begin
    if (!i_rst && o_pins.out_en_n === 1'b0) check_bit("write in read", 1'b1, o_pins.write_n);
    if (!i_rst && !o_pins.select_n && !o_pins.write_n) check_bit("host drive", 1'b1, o_pins.data_oe);
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    asram_addr_t a;
    repeat (12) @(posedge i_clock);
    @(negedge i_clock);
    i_rst = 1'b0;
    check_bit("select idle", 1'b1, o_pins.select_n);
    do_req(1'b1, 15'h0000, 8'ha5);
    do_req(1'b1, 15'h7fff, 8'h5a);
    do_req(1'b0, 15'h7fff, 8'h00);
    do_req(1'b1, 15'h0000, 8'h3c);
    do_req(1'b0, 15'h0000, 8'h00);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      a = r[16] ? r[14:0] : {12'h000, r[2:0]};
      do_req(r[31] || !ref_q.exists(a), a, r[24:17]);
    end
    complete_run();
  end
endmodule

/* File: test/asram_mem_model.sv */
// Purpose: behavioural static memory facing the host
// Assumes: pins come as the package struct, strobes active low
// Notes: a released bus shows the inverse of its last level
`timescale 1ns/1ns
module asram_mem_model (
  input wire asram_pkg::asram_pins_t i_pins,
  input wire logic i_slow,
  output logic [7:0] o_level
);
  import asram_pkg::*;
  logic [7:0] mem_q [0:32767];
  logic [7:0] last_q = 8'h00;
  wire wr_on = ~i_pins.select_n & ~i_pins.write_n;
  wire rd_on = ~i_pins.select_n & ~i_pins.out_en_n & i_pins.write_n;
  wire on_fast;
  wire on_slow;
  // late turn-on, quick turn-off
  assign #(3, 1) on_fast = rd_on;
  assign #(4, 1) on_slow = rd_on;
  wire drv = i_slow ? on_slow : on_fast;
  assign o_level = i_pins.data_oe ? i_pins.data_out : drv ? mem_q[i_pins.word_addr_bus] : ~last_q;
  // remember the last driven level
  always @* if (i_pins.data_oe || drv) last_q = o_level;
  // store at the end of the overlap
  always @(negedge wr_on) mem_q[i_pins.word_addr_bus] = o_level;
endmodule
